// ### bench/eeprom_dev_model.sv
module eeprom_dev_model #(
  parameter int BUSY_NS = 150000  // program time, kept short
) (
  // link and straps
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       wc_n,
  input  wire logic [2:0] pins,
  output logic            pull
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [256];  // array
  logic [7:0]  pg [16];    // page buffer
  logic [15:0] pv;         // filled page slots
  logic [7:0]  ptr, sh, rb;
  logic [3:0]  bc;
  logic [1:0]  ph;         // 0 dev, 1 addr, 2 data, 3 read
  logic        act, prot, lock, busy, mk;
  initial begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h5A;
    {pull, act, lock, busy, ptr, pv} = '0;
  end
  // start; deaf while programming
  always @(negedge sda) if (scl === 1'b1 && !busy) begin
    {act, ph, bc, prot} = {1'b1, 2'd0, 4'd0, 1'b0};
  end
  // stop commits the page or the lock; floating wc counts as low
  always @(posedge sda)
    if (scl === 1'b1 && !busy && (pv != 0 || prot && ph == 2)) begin
      for (int i = 0; i < 16; i++)
        if (pv[i] && wc_n !== 1'b1 && !(lock && !ptr[7]))
          mem[{ptr[7:4], 4'(i)}] = pg[i];
      if (prot) lock = 1'b1;
      {act, pv, busy} = {1'b0, 16'h0, 1'b1};
      #(BUSY_NS) busy = 1'b0;
    end
  // sample on rising clock; ninth clock is the acknowledge
  always @(posedge scl) if (act) begin
    if (bc != 8) begin
      sh = {sh[6:0], sda};
      bc = bc + 4'd1;
    end else begin
      if (mk && sda) act = 1'b0;
      else if (mk) begin
        rb = mem[ptr];
        ptr = ptr + 8'd1;
      end
      bc = 4'd0;
    end
  end
  // drive only on falling clock so data never moves while it is high
  always @(negedge scl) if (act) begin
    pull = 1'b0;
    if (bc == 8) begin
      mk = (ph == 3);
      if (!mk) pull = 1'b1;
      if (ph == 0) begin
        prot = sh[7:4] == 4'h6;
        pull = sh[3:1] == pins && (sh[7:4] == 4'hA || prot && !sh[0]);
        act = pull;
        ph = sh[0] ? 2'd3 : 2'd1;
        rb = mem[ptr];
        if (act && sh[0]) ptr = ptr + 8'd1;
      end else if (ph == 1) begin
        if (!prot) ptr = sh;
        ph = 2'd2;
      end else if (ph == 2 && !prot) begin
        pg[ptr[3:0]] = sh;
        pv[ptr[3:0]] = 1'b1;
        ptr[3:0] = ptr[3:0] + 4'd1;
      end
    end else if (ph == 3) pull = !rb[3'(7 - bc)];
  end
endmodule

// ### bench/eeprom_host_monitor.sv
module eeprom_host_monitor (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // command and status
  input wire logic cmd_valid_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic wr_take_o,
  input wire logic rd_valid_o,
  // link
  input wire logic scl_o,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic write_inhibit_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // accepted command; one clock-high phase lasts eight reference clocks or more
  sequence s_acc; cmd_valid_i && !busy_o; endsequence
  sequence s_hi; scl_o [*8]; endsequence
  property p_acc; s_acc |-> ##[1:2] busy_o; endproperty
  a_acc: assert property (p_acc) else $error("no busy");
  property p_done; done_o |-> !busy_o && $past(busy_o); endproperty
  a_done: assert property (p_done) else $error("bad done");
  property p_idle; !busy_o && !done_o |-> scl_o && !sda_oe_o; endproperty
  a_idle: assert property (p_idle) else $error("bus held");
  property p_wc; busy_o && $past(busy_o) |-> $stable(write_inhibit_n_o);
  endproperty
  a_wc: assert property (p_wc) else $error("wc moved");
  property p_take; wr_take_o |-> busy_o ##1 !wr_take_o; endproperty
  a_take: assert property (p_take) else $error("bad take");
  property p_rdv; rd_valid_o |=> !rd_valid_o && busy_o; endproperty
  a_rdv: assert property (p_rdv) else $error("bad rd");
  property p_od; sda_o == 1'b0; endproperty
  a_od: assert property (p_od) else $error("sda high");
  property p_hi; $rose(scl_o) |-> s_hi; endproperty
  a_hi: assert property (p_hi) else $error("short high");
endmodule
bind eeprom_host eeprom_host_monitor u_mon (.ref_clk_i, .rst_n_i,
  .cmd_valid_i, .busy_o, .done_o, .wr_take_o, .rd_valid_o, .scl_o,
  .sda_o, .sda_oe_o, .write_inhibit_n_o);

// ### bench/eeprom_host_tb.sv
module eeprom_host_tb
  import eeprom_host_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       cmd_valid_i = 1'b0;
  logic       cmd_inhibit_i = 1'b0;
  op_t        cmd_op_i = OP_POLL;
  logic [7:0] cmd_addr_i = 8'h00, cmd_len_i = 8'h00, wr_data_i = 8'h00;
  logic [2:0] cmd_chip_i = 3'h0;
  logic [7:0] rd_data_o, em [256], wbuf [16], cp, expq [$];
  logic       wr_take_o, rd_valid_o, busy_o, done_o, nack_o, scl_o, sda_o;
  logic       sda_oe_o, wc_n, pin0, pin1, pin2, dev_pull, lock = 1'b0;
  wire        sda_w = !(sda_oe_o || dev_pull);  // pulled up when free
  int         wi, compares = 0, miscompares = 0;
  always #20 ref_clk_i = ~ref_clk_i;
  eeprom_host u_dut (.ref_clk_i, .rst_n_i, .cmd_valid_i, .cmd_op_i,
    .cmd_addr_i, .cmd_len_i, .cmd_inhibit_i, .cmd_chip_i, .wr_data_i,
    .wr_take_o, .rd_data_o, .rd_valid_o, .busy_o, .done_o, .nack_o, .scl_o,
    .sda_i(sda_w), .sda_o, .sda_oe_o, .write_inhibit_n_o(wc_n),
    .chip_addr_bit0_o(pin0), .chip_addr_bit1_o(pin1), .chip_addr_bit2_o(pin2));
  eeprom_dev_model u_dev (.scl(scl_o), .sda(sda_w), .wc_n(wc_n),
    .pins({pin2, pin1, pin0}), .pull(dev_pull));
  task automatic check(logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one command, waited for under a bound
  task automatic run(op_t op, logic [7:0] a, logic [7:0] n, logic inh);
    int t;
    @(posedge ref_clk_i);
    cmd_op_i <= op;
    {cmd_addr_i, cmd_len_i, cmd_inhibit_i} <= {a, n, inh};
    {cmd_chip_i, wr_data_i, cmd_valid_i} <= {3'($urandom), wbuf[0], 1'b1};
    wi = 0;
    @(posedge ref_clk_i);
    cmd_valid_i <= 1'b0;
    t = 0;
    do @(posedge ref_clk_i) #1 t++;
    while (done_o !== 1'b1 && t < 20000);
    // a command that never finishes ends the run as a failure
    if (done_o !== 1'b1) begin
      miscompares++;
      end_of_test();
    end
  endtask
  // poll at least once: a clean write still leaves the device busy
  task automatic rdy;
    run(OP_POLL, 8'h00, 8'h00, 1'b0);
    for (int k = 0; k < 4 && nack_o !== 1'b0; k++)
      run(OP_POLL, 8'h00, 8'h00, 1'b0);
  endtask
  // expected array follows page wrap, inhibit and lock
  task automatic wr(logic [7:0] a, int n, logic inh);
    for (int i = 0; i < n; i++) begin
      wbuf[i] = 8'($urandom);
      if (!inh && !(lock && !a[7])) em[{a[7:4], a[3:0] + 4'(i)}] = wbuf[i];
    end
    cp = {a[7:4], a[3:0] + 4'(n)};
    run(OP_WRITE, a, 8'(n - 1), inh);
    check({7'h00, nack_o}, 8'h00);
  endtask
  task automatic rd(op_t op, logic [7:0] a, int n);
    if (op == OP_RAND_READ) cp = a;
    for (int i = 0; i < n; i++)
      expq.push_back(em[cp++]);
    run(op, a, 8'(n - 1), 1'b0);
    check({7'h00, nack_o}, 8'h00);
  endtask
  // feed the next write byte; compare each read byte with oldest note
  always @(posedge ref_clk_i) begin
    if (wr_take_o === 1'b1) wr_data_i <= wbuf[++wi];
    if (rd_valid_o === 1'b1) check(rd_data_o, expq.pop_front());
  end
  initial begin
    for (int i = 0; i < 256; i++)
      em[i] = 8'(i) ^ 8'h5A;
    void'($urandom(32'hD1502A93));
    repeat (20) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    wr(8'hFE, 3, 1'b0);
    run(OP_POLL, 8'h00, 8'h00, 1'b0);
    check({7'h00, nack_o}, 8'h01);
    rdy();
    rd(OP_RAND_READ, 8'hFE, 3);
    rd(OP_CUR_READ, 8'h00, 1);
    rd(OP_RAND_READ, 8'hF0, 1);
    wr(8'h10, 1, 1'b1);
    rdy();
    run(OP_PROTECT, 8'h00, 8'h00, 1'b0);
    check({7'h00, nack_o}, 8'h00);
    lock = 1'b1;
    rdy();
    wr(8'h11, 1, 1'b0);
    rdy();
    rd(OP_RAND_READ, 8'h10, 3);
    check(8'(expq.size()), 8'h00);
    end_of_test();
  end
  // hang guard, about three quarters longer than the whole sequence
  initial begin
    #8000000;
    miscompares++;
    end_of_test();
  end
endmodule

// ### src/eeprom_host.sv
// Summary of operation
// - host holds write control steady start to stop
// - byte write: address, word address, one data
// - page write sends up to sixteen data bytes; host sends cmd_len_i + 1, up to 256
// - poll: write address, ack means cycle done
// - after poll, stop before starting a read
// - protect: nibble 0110, two ignored acked bytes
// - reads use read bit set, three forms
// - host ends read with no-ack then stop
// - current read: one byte, no-ack, stop
// - random read: dummy write, repeated start
module eeprom_host
  import eeprom_host_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  // command port
  input  wire logic       cmd_valid_i,
  input  wire op_t        cmd_op_i,
  input  wire logic [7:0] cmd_addr_i,
  input  wire logic [7:0] cmd_len_i,
  input  wire logic       cmd_inhibit_i,
  input  wire logic [2:0] cmd_chip_i,
  // write data stream
  input  wire logic [7:0] wr_data_i,
  output logic            wr_take_o,
  // read data stream
  output logic [7:0]      rd_data_o,
  output logic            rd_valid_o,
  // status
  output logic            busy_o,
  output logic            done_o,
  output logic            nack_o,
  // two-wire link and device straps
  output logic            scl_o,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  output logic            write_inhibit_n_o,
  output logic            chip_addr_bit0_o,
  output logic            chip_addr_bit1_o,
  output logic            chip_addr_bit2_o
);

  // slave address byte from prefix, pins and direction
  function automatic logic [7:0] dev_byte(input logic [3:0] prefix,
                                          input logic [2:0] pins,
                                          input logic       rd);
    dev_byte = {prefix, pins, rd};
  endfunction

  logic [6:0] qcnt;       // cycles within a quarter
  logic       tick;       // quarter boundary strobe
  logic       sda_meta;   // first synchroniser stage
  logic       sda_sync;   // data line as seen by the sequencer
  state_t     state;      // sequencer state
  logic [1:0] q;          // quarter within the current bit
  logic       half;       // second pass of start or stop
  op_t        op;         // command in progress
  kind_t      kind;       // byte now on the wire
  logic       rd_phase;   // address byte carries the read bit
  logic [3:0] bitn;       // bit index, ACK_SLOT is the ack bit
  logic [7:0] shreg;      // shift register for both directions
  logic [7:0] cnt;        // bytes left after the current one
  logic [7:0] addr;       // word address of the command
  logic [2:0] chip;       // latched device address pins
  logic       tx_kind;    // host drives the byte

  assign tx_kind = (kind != K_RDATA);

  // free-running quarter timer; start waits at most one quarter
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      qcnt <= 7'h00;
      tick <= 1'b0;
    end else begin
      tick <= (qcnt == QUARTER_LAST);
      if (qcnt == QUARTER_LAST) begin
        qcnt <= 7'h00;
      end else begin
        qcnt <= qcnt + 7'h01;
      end
    end
  end

  // two-stage synchroniser for the data pin
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
    end else begin
      sda_meta <= sda_i;
      sda_sync <= sda_meta;
    end
  end

  // straps: latched per command and held through the transfer
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      write_inhibit_n_o <= 1'b0;  // low leaves writes enabled
      chip_addr_bit0_o  <= 1'b0;
      chip_addr_bit1_o  <= 1'b0;
      chip_addr_bit2_o  <= 1'b0;
    end else if (state == S_IDLE && cmd_valid_i) begin
      // only changes between transfers, never inside one
      write_inhibit_n_o <= cmd_inhibit_i;  // high blocks writes
      chip_addr_bit0_o  <= cmd_chip_i[0];
      chip_addr_bit1_o  <= cmd_chip_i[1];
      chip_addr_bit2_o  <= cmd_chip_i[2];
    end
  end

  // bus sequencer; data line is open drain, driven only low
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state      <= S_IDLE;
      q          <= 2'h0;
      half       <= 1'b0;
      op         <= OP_WRITE;
      kind       <= K_DEV;
      rd_phase   <= 1'b0;
      bitn       <= 4'h0;
      shreg      <= 8'h00;
      cnt        <= 8'h00;
      addr       <= 8'h00;
      chip       <= 3'h0;
      scl_o      <= 1'b1;
      sda_o      <= 1'b0;
      sda_oe_o   <= 1'b0;
      busy_o     <= 1'b0;
      done_o     <= 1'b0;
      nack_o     <= 1'b0;
      wr_take_o  <= 1'b0;
      rd_valid_o <= 1'b0;
      rd_data_o  <= 8'h00;
    end else begin
      done_o     <= 1'b0;
      wr_take_o  <= 1'b0;
      rd_valid_o <= 1'b0;
      unique case (state)
        S_IDLE: begin
          if (cmd_valid_i) begin
            // current read skips the address phase
            state    <= S_START;
            busy_o   <= 1'b1;
            nack_o   <= 1'b0;
            op       <= cmd_op_i;
            addr     <= cmd_addr_i;
            cnt      <= cmd_len_i;
            chip     <= cmd_chip_i;
            rd_phase <= (cmd_op_i == OP_CUR_READ);
            q        <= 2'h0;
            half     <= 1'b0;
          end
        end
        S_START: if (tick) begin
          q <= q + 2'h1;
          if (!half) begin
            // first pass: lift both lines with clock low first
            unique case (q)
              2'h0: scl_o <= 1'b0;
              2'h1: sda_oe_o <= 1'b0;
              2'h2: scl_o <= 1'b1;
              2'h3: half <= 1'b1;
            endcase
          end else begin
            // second pass: data falls while clock is high
            if (q == 2'h0) begin
              sda_oe_o <= 1'b1;
            end
            if (q == 2'h3) begin
              half  <= 1'b0;
              state <= S_BIT;
              kind  <= K_DEV;
              bitn  <= 4'h0;
              // prefix, pins and direction bit
              shreg <= dev_byte((op == OP_PROTECT) ? PREFIX_PROT
                                : PREFIX_MEM, chip, rd_phase);
            end
          end
        end
        S_BIT: if (tick) begin
          q <= q + 2'h1;
          unique case (q)
            2'h0: scl_o <= 1'b0;
            2'h1: begin
              if (bitn != ACK_SLOT) begin
                sda_oe_o <= tx_kind & ~shreg[7];
              end else begin
                // ack all but the last read byte
                sda_oe_o <= ~tx_kind & (cnt != 8'h00);
              end
            end
            2'h2: scl_o <= 1'b1;
            2'h3: begin
              bitn <= bitn + 4'h1;
              if (bitn != ACK_SLOT) begin
                shreg <= {shreg[6:0], sda_sync};
                if (bitn == 4'h7 && !tx_kind) begin
                  rd_data_o  <= {shreg[6:0], sda_sync};
                  rd_valid_o <= 1'b1;
                end
              end else begin
                bitn <= 4'h0;
                if (tx_kind && sda_sync) begin
                  // missing ack: busy device or no match
                  nack_o <= 1'b1;
                  state  <= S_STOP;
                end else begin
                  unique case (kind)
                    K_DEV: begin
                      if (op == OP_POLL) begin
                        // poll always ends with stop
                        state <= S_STOP;
                      end else if (rd_phase) begin
                        kind <= K_RDATA;
                      end else begin
                        kind  <= K_ADDR;
                        shreg <= (op == OP_PROTECT) ? FILL_BYTE : addr;
                      end
                    end
                    K_ADDR: begin
                      if (op == OP_RAND_READ) begin
                        // repeated start after dummy write
                        rd_phase <= 1'b1;
                        state    <= S_START;
                      end else begin
                        // first data byte of write or protect
                        kind      <= K_WDATA;
                        shreg     <= (op == OP_PROTECT) ? FILL_BYTE
                                     : wr_data_i;
                        wr_take_o <= (op == OP_WRITE);
                      end
                    end
                    K_WDATA: begin
                      if (op == OP_PROTECT || cnt == 8'h00) begin
                        // protect sends one data byte only
                        state <= S_STOP;
                      end else begin
                        // further page bytes, counted by user
                        cnt       <= cnt - 8'h01;
                        shreg     <= wr_data_i;
                        wr_take_o <= 1'b1;
                      end
                    end
                    K_RDATA: begin
                      if (cnt == 8'h00) begin
                        // last byte was not acked, now stop
                        state <= S_STOP;
                      end else begin
                        cnt <= cnt - 8'h01;
                      end
                    end
                  endcase
                end
              end
            end
          endcase
        end
        S_STOP: if (tick) begin
          q <= q + 2'h1;
          if (!half) begin
            // first pass: pull data low under a low clock
            unique case (q)
              2'h0: scl_o <= 1'b0;
              2'h1: sda_oe_o <= 1'b1;
              2'h2: scl_o <= 1'b1;
              2'h3: half <= 1'b1;
            endcase
          end else begin
            // data rises with clock high; device starts its cycle
            if (q == 2'h0) begin
              sda_oe_o <= 1'b0;
            end
            if (q == 2'h3) begin
              half  <= 1'b0;
              state <= S_BUF;
            end
          end
        end
        S_BUF: if (tick) begin
          // one idle bit keeps the bus free before the next start
          q <= q + 2'h1;
          if (q == 2'h3) begin
            state  <= S_IDLE;
            busy_o <= 1'b0;
            done_o <= 1'b1;
          end
        end
      endcase
    end
  end

endmodule

// ### src/eeprom_host_pkg.sv
package eeprom_host_pkg;

  // reference clock and bus quarter-bit timing
  localparam int CLK_PERIOD_NS = 40;
  // one quarter of a 100 kHz bit; high and low halves take two quarters
  localparam int QUARTER_NS    = 2500;
  // least time, so round the cycle count up
  localparam int QUARTER_CYC   = (QUARTER_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam logic [6:0] QUARTER_LAST = 7'(QUARTER_CYC - 1);

  // slave address upper nibbles
  localparam logic [3:0] PREFIX_MEM   = 4'hA;
  localparam logic [3:0] PREFIX_PROT  = 4'h6;

  // bit counter value of the acknowledge slot
  localparam logic [3:0] ACK_SLOT     = 4'h8;
  // don't-care byte sent in the protect command
  localparam logic [7:0] FILL_BYTE    = 8'h00;

  // commands accepted on the user port
  typedef enum logic [2:0] {
    OP_WRITE,
    OP_RAND_READ,
    OP_CUR_READ,
    OP_PROTECT,
    OP_POLL
  } op_t;

  // kind of byte currently on the wire
  typedef enum logic [1:0] {
    K_DEV,
    K_ADDR,
    K_WDATA,
    K_RDATA
  } kind_t;

  // bus sequencer states
  typedef enum logic [2:0] {
    S_IDLE,
    S_START,
    S_BIT,
    S_STOP,
    S_BUF
  } state_t;

endpackage
